/* File: shared/uime_pkg.sv */
// Package for the I2C mode engine: register map, field positions, timing.
// Assumes a single 20 MHz system clock and an AHB-Lite register bus.
package uime_pkg;

    // ****************************************************************
    // Register byte addresses
    // ****************************************************************
    localparam logic [7:0] ADDR_CTRL   = 8'h00; // Mode, layout, arbitration, select.
    localparam logic [7:0] ADDR_MODE3  = 8'h04; // i2c_special_mode_three.
    localparam logic [7:0] ADDR_MODE4  = 8'h08; // i2c_special_mode_four.
    localparam logic [7:0] ADDR_STATUS = 8'h0C; // Events and flags.
    localparam logic [7:0] ADDR_RXBUF  = 8'h10; // receive_buffer.
    localparam logic [7:0] ADDR_TXBUF  = 8'h14; // Transmit data.
    localparam logic [7:0] ADDR_BAUD   = 8'h18; // baud_divider.

    // ****************************************************************
    // Field positions
    // ****************************************************************
    // Control register.
    localparam int CTL_SMD_LO    = 0;  // serial_mode_field, 3 bits.
    localparam int CTL_I2C_MODE_SELECT      = 3;
    localparam int CTL_LAYOUT    = 4;
    localparam int CTL_ABC       = 5;
    localparam int CTL_ALS       = 6;
    localparam int CTL_CLOCK_SOURCE_SELECT     = 7;
    localparam int CTL_SDA_INIT  = 8;  // Port value for the initial SDA.
    // Mode three register.
    localparam int M3_CLOCK_DELAY_SELECT       = 1;
    // Mode four register.
    localparam int M4_STA        = 0;
    localparam int M4_RSTA       = 1;
    localparam int M4_STP        = 2;
    localparam int M4_SEL        = 3;
    localparam int M4_ACK_DATA_VALUE       = 4;
    localparam int M4_ACK_OUTPUT_ENABLE       = 5;
    localparam int M4_SCL_RELEASE_ON_STOP      = 6;
    localparam int M4_SCL_HOLD_AFTER_NINTH       = 7;
    // Status register; write one to clear bits 0 to 3, and bit 4 with bytewise timing.
    localparam int ST_STSP       = 0;
    localparam int ST_TXEV       = 1;
    localparam int ST_RXEV       = 2;
    localparam int ST_DMA1       = 3;
    localparam int ST_ARB        = 4;
    localparam int ST_BUSY       = 5;

    localparam logic [2:0] SMD_I2C  = 3'h2;
    localparam logic [2:0] SMD_OFF  = 3'h0;
    localparam logic [3:0] BIT_NINE = 4'h9;
    localparam logic [3:0] BIT_ONE  = 4'h1;
    localparam logic [3:0] BIT_ZERO = 4'h0;
    localparam logic [7:0] RST8     = 8'h00;
    localparam logic [8:0] RST9     = 9'h000;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef enum logic [2:0] {
        UIME_GEN_IDLE, UIME_GEN_A, UIME_GEN_B, UIME_GEN_C
    } uime_gen_t;

endpackage : uime_pkg

/* File: design/uime_engine.sv */
// I2C special mode engine of a serial port, with its AHB-Lite registers.
// Assumes SDA and SCL are open-drain pads resolved outside; pad inputs are
// asynchronous and pass a two-stage synchroniser here.
// Summary of operation
// - Falling SDA while SCL high flags a start and raises the shared request.
// - Rising SDA while SCL high flags a stop and raises the shared request.
// - Start and stop share one request; bus-busy tells them apart.
// - Writing start, restart or stop request bits generates that condition.
// - With select at 0, pins carry only transfer clock and data.
// - Request on detection with select 0, on generation end with select 1.
// - Each sent bit is compared with SDA at every SCL rising edge but the ninth.
// - Bitwise timing: flag follows each check, set on mismatch, else cleared.
// - Bytewise timing: any mismatch sets flag at ninth falling edge.
// - With SDA stop on loss, SDA released at the mismatch, before the bytewise flag sets.
// - Layout 0: transmit source is NACK detection at ninth rising edge.
// - Layout 0 receive source is ACK; layout 1 is ninth falling edge.
// - Layout 1 transmit event at ninth rise, or the falling edge after the ninth fall with delay.
// - Layout 1 buffer loads at ninth fall, again at rise with delay.
// - Layout 1 stores bits one to seven in 6:0, eighth in bit 8.
// - DMA1 source is ACK with layout 0, ninth fall with layout 1.
// - Initial SDA level is the port value set while mode field is off.
// - SCL idles high without clock delay, low with clock delay.
// - Acknowledge output enabled drives the ack data bit during ninth clock.
// - Master with release on stop lets SCL go once a stop is seen.
// - Slave with hold after ninth and clock delay holds SCL low after clock ten falls.
// - Master bit rate is clock over two times divider plus one.
`timescale 1ns/100ps
`default_nettype none
module uime_engine (
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        scl_in,
    output logic             scl_out,
    output logic             scl_oe,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    output logic             stsp_irq,
    output logic             tx_irq,
    output logic             rx_irq,
    output logic             dma1_req
);
    import uime_pkg::*;

    // ****************************************************************
    // Registers and state
    // ****************************************************************
    logic [8:0] ctrl_q;
    logic [7:0] mode3_q, mode4_q, baud_q, txbuf_q;
    logic [8:0] rxbuf_q;
    logic [7:0] shift_q;
    logic [4:0] ev_q;
    logic       arb_q, arb_acc_q, busy_q;
    logic [3:0] bitcnt_q;
    logic [7:0] brg_q;
    logic       iscl_q, hold_q, rel_q;
    logic       sda_drv_q;
    logic [1:0] scl_s_q, sda_s_q;
    logic       scl_p_q, sda_p_q;
    uime_gen_t  gen_q;
    logic       wr_pend_q;
    logic [7:0] waddr_q;

    logic       en, master, clock_delay_select, layout, sel;
    logic       scl_r, scl_f, start_det, stop_det;
    logic       tick, gen_done, ninth_rise, ninth_fall, tenth_fall;
    logic       mism, txbit, ack_phase;
    logic       set_tx, set_rx, set_dma, set_stsp;
    logic       sw_clr;
    logic [4:0] clr_mask;

    assign en     = (ctrl_q[CTL_SMD_LO +: 3] == SMD_I2C) && ctrl_q[CTL_I2C_MODE_SELECT];
    assign master = !ctrl_q[CTL_CLOCK_SOURCE_SELECT];
    assign clock_delay_select   = mode3_q[M3_CLOCK_DELAY_SELECT];
    assign layout = ctrl_q[CTL_LAYOUT];
    assign sel    = mode4_q[M4_SEL];

    // ****************************************************************
    // Pin synchronisers and edge detection
    // ****************************************************************
    // Only the second stage feeds the edge detectors below.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            scl_s_q <= 2'h3;
            sda_s_q <= 2'h3;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_s_q <= {scl_s_q[0], scl_in};
            sda_s_q <= {sda_s_q[0], sda_in};
            scl_p_q <= scl_s_q[1];
            sda_p_q <= sda_s_q[1];
        end
    end

    assign scl_r = scl_s_q[1] && !scl_p_q;
    assign scl_f = !scl_s_q[1] && scl_p_q;
    assign start_det = en && scl_s_q[1] && scl_p_q && sda_p_q && !sda_s_q[1];
    assign stop_det = en && scl_s_q[1] && scl_p_q && !sda_p_q && sda_s_q[1];

    // ****************************************************************
    // Baud divider
    // ****************************************************************
    // Half period is divider plus one clocks, so a bit takes 2(n+1).
    always_ff @(posedge clk_sys) begin
        if (!rst_b || !en) begin
            brg_q <= RST8;
        end else if (brg_q == RST8) begin
            brg_q <= baud_q;
        end else begin
            brg_q <= brg_q - 8'h01;
        end
    end
    assign tick = en && (brg_q == RST8);

    // ****************************************************************
    // Condition generator
    // ****************************************************************
    // Request bits drive a short sequence; only when selected.
    always_ff @(posedge clk_sys) begin
        if (!rst_b || !en || !sel) begin
            gen_q <= UIME_GEN_IDLE;
        end else if (tick) begin
            case (gen_q)
                UIME_GEN_IDLE: begin
                    if (mode4_q[M4_STA] || mode4_q[M4_RSTA] ||
                        mode4_q[M4_STP]) begin
                        gen_q <= UIME_GEN_A;
                    end
                end
                UIME_GEN_A: gen_q <= UIME_GEN_B;
                UIME_GEN_B: gen_q <= UIME_GEN_C;
                default:    gen_q <= UIME_GEN_IDLE;
            endcase
        end
    end
    assign gen_done = tick && (gen_q == UIME_GEN_C);

    // ****************************************************************
    // Internal SCL and bit counter
    // ****************************************************************
    // Idle level of SCL follows clock delay; clock runs only with data.
    always_ff @(posedge clk_sys) begin
        if (!rst_b || !en) begin
            iscl_q <= 1'b1;
        end else if (gen_q != UIME_GEN_IDLE && sel) begin
            iscl_q <= !mode4_q[M4_STP] || (gen_q != UIME_GEN_A);
        end else if (master && bitcnt_q != BIT_ZERO && tick) begin
            iscl_q <= !iscl_q;
        end else if (bitcnt_q == BIT_ZERO) begin
            iscl_q <= !clock_delay_select;
        end
    end

    // Counts bits of a byte on SCL falling edges; a byte holds nine clocks.
    // Zero means no transfer, so a master clocks only after a start.
    always_ff @(posedge clk_sys) begin
        if (!rst_b || !en || stop_det) begin
            bitcnt_q <= BIT_ZERO;
        end else if (start_det) begin
            bitcnt_q <= BIT_ONE;
        end else if (scl_f && bitcnt_q != BIT_ZERO) begin
            bitcnt_q <= (bitcnt_q == BIT_NINE) ? BIT_ONE : bitcnt_q + BIT_ONE;
        end
    end

    assign ninth_rise = scl_r && (bitcnt_q == BIT_NINE);
    assign ninth_fall = scl_f && (bitcnt_q == BIT_NINE);
    assign tenth_fall = scl_f && (bitcnt_q == BIT_ONE) && hold_q == 1'b0
                        && rel_q;
    assign ack_phase  = (bitcnt_q == BIT_NINE);

    // Tracks that a ninth clock has ended, so the next falling edge is tenth.
    always_ff @(posedge clk_sys) begin
        if (!rst_b || !en) begin
            rel_q <= 1'b0;
        end else if (ninth_fall) begin
            rel_q <= 1'b1;
        end else if (scl_f) begin
            rel_q <= 1'b0;
        end
    end

    // ****************************************************************
    // Shift register and receive buffer
    // ****************************************************************
    assign txbit = shift_q[7];

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            shift_q <= RST8;
        end else if (start_det || (ninth_fall && en)) begin
            shift_q <= txbuf_q;
        end else if (scl_r && !ack_phase) begin
            shift_q <= {shift_q[6:0], sda_s_q[1]};
        end
    end

    // Layout 0 loads at ninth rise; layout 1 at ninth fall, with clock delay also at rise.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            rxbuf_q <= RST9;
        end else if (ninth_rise && (!layout || clock_delay_select)) begin
            rxbuf_q <= {sda_s_q[1], shift_q};
        end else if (ninth_fall && layout) begin
            // Bits one to seven low, eighth in bit 8.
            rxbuf_q <= {shift_q[0], rxbuf_q[7], shift_q[7:1]};
        end
    end

    // ****************************************************************
    // Arbitration
    // ****************************************************************
    // Compare on each SCL rising edge while driving data bits.
    assign mism = scl_r && !ack_phase && txbit && !sda_s_q[1];

    always_ff @(posedge clk_sys) begin
        if (!rst_b || !en) begin
            arb_q     <= 1'b0;
            arb_acc_q <= 1'b0;
        end else if (!ctrl_q[CTL_ABC]) begin
            if (scl_r && !ack_phase) begin
                arb_q <= mism;
            end
        end else begin
            // Bytewise: latch at ninth fall; software clears it.
            if (ninth_fall) begin
                arb_q     <= arb_q || arb_acc_q || mism;
                arb_acc_q <= 1'b0;
            end else if (mism) begin
                arb_acc_q <= 1'b1;
            end else if (sw_clr && clr_mask[ST_ARB]) begin
                arb_q <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Bus busy and events
    // ****************************************************************
    // Busy follows start and stop; it tells them apart.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            busy_q <= 1'b0;
        end else if (start_det) begin
            busy_q <= 1'b1;
        end else if (stop_det) begin
            busy_q <= 1'b0;
        end
    end

    // Detection or generation end, per the select bit.
    assign set_stsp = sel ? gen_done : (start_det || stop_det);
    // Transmit source per layout and clock delay.
    assign set_tx = !layout ? (ninth_rise && sda_s_q[1])
                  : (clock_delay_select ? tenth_fall : ninth_rise);
    assign set_rx = !layout ? (ninth_rise && !sda_s_q[1]) : ninth_fall;
    // DMA channel 1 source per layout.
    assign set_dma = set_rx;

    // Hardware set wins over a software clear in the same cycle.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            ev_q <= 5'h00;
        end else begin
            ev_q[ST_STSP] <= set_stsp ||
                (ev_q[ST_STSP] && !(sw_clr && clr_mask[ST_STSP]));
            ev_q[ST_TXEV] <= set_tx ||
                (ev_q[ST_TXEV] && !(sw_clr && clr_mask[ST_TXEV]));
            ev_q[ST_RXEV] <= set_rx ||
                (ev_q[ST_RXEV] && !(sw_clr && clr_mask[ST_RXEV]));
            ev_q[ST_DMA1] <= set_dma ||
                (ev_q[ST_DMA1] && !(sw_clr && clr_mask[ST_DMA1]));
            ev_q[ST_ARB] <= 1'b0;
        end
    end

    assign stsp_irq = ev_q[ST_STSP];
    assign tx_irq   = ev_q[ST_TXEV];
    assign rx_irq   = ev_q[ST_RXEV];
    assign dma1_req = ev_q[ST_DMA1];

    // ****************************************************************
    // SCL and SDA drivers
    // ****************************************************************
    // Slave hold after the ninth; master release after a stop.
    always_ff @(posedge clk_sys) begin
        if (!rst_b || !en) begin
            hold_q <= 1'b0;
        end else if (!mode4_q[M4_SCL_HOLD_AFTER_NINTH]) begin
            hold_q <= 1'b0;
        end else if (!master && clock_delay_select && scl_f && rel_q) begin
            hold_q <= 1'b1;
        end
    end

    // SDA is released in the cycle a mismatch is seen; the bitwise lost flag rises then too.
    // Ack bit driven during the ninth clock; initial level.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            sda_drv_q <= 1'b1;
        end else if (ctrl_q[CTL_SMD_LO +: 3] == SMD_OFF) begin
            sda_drv_q <= ctrl_q[CTL_SDA_INIT];
        end else if (gen_q != UIME_GEN_IDLE && sel) begin
            sda_drv_q <= (mode4_q[M4_STP] ? (gen_q == UIME_GEN_C)
                                          : (gen_q == UIME_GEN_A));
        end else if (ctrl_q[CTL_ALS] && (mism || arb_q)) begin
            sda_drv_q <= 1'b1;
        end else if (!scl_s_q[1]) begin
            sda_drv_q <= ack_phase ? (mode4_q[M4_ACK_OUTPUT_ENABLE] ? mode4_q[M4_ACK_DATA_VALUE]
                                                       : 1'b1)
                                   : txbit;
        end
    end

    // Open-drain pins: drive low only; release otherwise.
    assign sda_out = 1'b0;
    assign sda_oe  = en && !sda_drv_q;
    assign scl_out = 1'b0;
    assign scl_oe  = en && (hold_q || (master && !iscl_q &&
                     !(mode4_q[M4_SCL_RELEASE_ON_STOP] && !busy_q && bitcnt_q == BIT_ZERO)));

    // ****************************************************************
    // AHB-Lite slave
    // ****************************************************************
    // Zero wait states; writes commit in the data phase.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign sw_clr    = wr_pend_q && (waddr_q == ADDR_STATUS);
    assign clr_mask  = hwdata[4:0];

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            wr_pend_q <= 1'b0;
            waddr_q   <= RST8;
        end else if (hready) begin
            wr_pend_q <= hsel && hwrite && (htrans == HTRANS_NONSEQ);
            waddr_q   <= haddr[7:0];
        end
    end

    // Register writes; the generator clears request bits when it finishes.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            ctrl_q  <= RST9;
            mode3_q <= RST8;
            mode4_q <= RST8;
            baud_q  <= RST8;
            txbuf_q <= RST8;
        end else begin
            if (wr_pend_q) begin
                if (waddr_q == ADDR_CTRL) begin
                    ctrl_q <= hwdata[8:0];
                end else if (waddr_q == ADDR_MODE3) begin
                    mode3_q <= hwdata[7:0];
                end else if (waddr_q == ADDR_MODE4) begin
                    mode4_q <= hwdata[7:0];
                end else if (waddr_q == ADDR_BAUD) begin
                    baud_q <= hwdata[7:0];
                end else if (waddr_q == ADDR_TXBUF) begin
                    txbuf_q <= hwdata[7:0];
                end
            end
            if (gen_done) begin
                mode4_q[M4_STP:M4_STA] <= 3'h0;
            end
        end
    end

    // Read data registered in the address phase, shown in the data phase.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && !hwrite) begin
            if (haddr[7:0] == ADDR_CTRL) begin
                hrdata <= {23'h0, ctrl_q};
            end else if (haddr[7:0] == ADDR_MODE3) begin
                hrdata <= {24'h0, mode3_q};
            end else if (haddr[7:0] == ADDR_MODE4) begin
                hrdata <= {24'h0, mode4_q};
            end else if (haddr[7:0] == ADDR_STATUS) begin
                hrdata <= {26'h0, busy_q, arb_q, ev_q[3:0]};
            end else if (haddr[7:0] == ADDR_RXBUF) begin
                hrdata <= {23'h0, rxbuf_q};
            end else if (haddr[7:0] == ADDR_TXBUF) begin
                hrdata <= {24'h0, txbuf_q};
            end else if (haddr[7:0] == ADDR_BAUD) begin
                hrdata <= {24'h0, baud_q};
            end else begin
                hrdata <= 32'h0000_0000;
            end
        end
    end

endmodule : uime_engine
`default_nettype wire

/* File: test/uime_engine_monitor.sv */
// Port checker for the I2C mode engine.
// Assumes the bench is the only bus master and that writes decode as mapped.
`timescale 1ns/100ps
`default_nettype none
module uime_engine_monitor
    import uime_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        rst_b,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        scl_in,
    input wire logic        sda_in,
    input wire logic        scl_out,
    input wire logic        sda_out,
    input wire logic        scl_oe,
    input wire logic        sda_oe,
    input wire logic        stsp_irq
);
    logic [7:0] a_q;
    logic       w_q;
    logic       r_q;
    logic [3:0] c_q;
    logic       s_q;
    wire logic  on = c_q == {1'b1, SMD_I2C};
    wire logic  take = hsel && hready && htrans == HTRANS_NONSEQ;

    // Shadow of mode and select bits; only the settings the checks need.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            w_q <= 1'b0;
            r_q <= 1'b0;
            c_q <= 4'h0;
            s_q <= 1'b0;
        end else begin
            w_q <= take && hwrite;
            r_q <= take && !hwrite && haddr[7:0] == 8'h1C;
            a_q <= haddr[7:0];
            if (w_q && a_q == ADDR_CTRL) c_q <= hwdata[3:0];
            if (w_q && a_q == ADDR_MODE4) s_q <= hwdata[M4_SEL];
        end
    end

    // All checks share the system clock and stay quiet during reset.
    default clocking mon_cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    chk_start_seen: assert property (
        on && !s_q && $fell(sda_in) && scl_in && $past(scl_in)
        |-> ##[1:8] stsp_irq)
        else $error("start on bus not flagged");
    chk_stop_seen: assert property (
        on && !s_q && $rose(sda_in) && scl_in && $past(scl_in)
        |-> ##[1:8] stsp_irq)
        else $error("stop on bus not flagged");
    chk_irq_sticky: assert property (
        stsp_irq && !(w_q && a_q == ADDR_STATUS) |=> stsp_irq)
        else $error("condition request dropped without a clear");
    chk_reset_quiet: assert property (
        $rose(rst_b) |-> !scl_oe && !sda_oe && !stsp_irq && hrdata == 32'h0)
        else $error("outputs active after reset");
    chk_scl_off_idle: assert property (
        !on && !$past(on) |-> !scl_oe)
        else $error("SCL driven while interface off");
    chk_open_drain: assert property (
        !scl_out && !sda_out)
        else $error("pad drives a high level");
    chk_ready_okay: assert property (
        hreadyout && !hresp)
        else $error("bus answer not ready and okay");
    chk_unmapped_zero: assert property (
        r_q |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
endmodule : uime_engine_monitor

bind uime_engine uime_engine_monitor u_mon (
    .clk_sys(clk_sys), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .scl_in(scl_in), .sda_in(sda_in), .scl_out(scl_out),
    .sda_out(sda_out), .scl_oe(scl_oe), .sda_oe(sda_oe),
    .stsp_irq(stsp_irq));
`default_nettype wire

/* File: test/uime_peer.sv */
// Other bus party: makes start and stop, counts conditions on the wires.
// Assumes pulled-up lines resolved by the bench from every pull-down.
`timescale 1ns/100ps
`default_nettype none
module uime_peer (
    input  wire logic clk_sys,
    input  wire logic scl,
    input  wire logic sda,
    output var logic  scl_pull,
    output var logic  sda_pull,
    output var int    n_start,
    output var int    n_stop
);
    logic scl_q;
    logic sda_q;

    initial begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
        n_start = 0;
        n_stop = 0;
    end

    // Eight clocks a step keeps SCL high long enough for two samples.
    task automatic gen_start();
        sda_pull <= 1'b1;
        repeat (8) @(posedge clk_sys);
        scl_pull <= 1'b1;
        repeat (8) @(posedge clk_sys);
    endtask : gen_start

    task automatic gen_stop();
        scl_pull <= 1'b0;
        repeat (8) @(posedge clk_sys);
        sda_pull <= 1'b0;
        repeat (8) @(posedge clk_sys);
    endtask : gen_stop

    always @(posedge clk_sys) begin
        scl_q <= scl;
        sda_q <= sda;
        if (scl && scl_q && sda_q && !sda) n_start <= n_start + 1;
        if (scl && scl_q && !sda_q && sda) n_stop <= n_stop + 1;
    end
endmodule : uime_peer
`default_nettype wire

/* File: test/uime_engine_tb_top.sv */
// Bench for the I2C mode engine: AHB-Lite master tasks and a bus peer.
// Assumes a zero-wait slave; the peer shares the pulled-up lines.
`timescale 1ns/100ps
`default_nettype none
module uime_engine_tb_top;
    import uime_pkg::*;
    logic        clk_sys = 1'b0;
    logic        rst_b = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    wire logic   hready;
    wire logic   p_scl, p_sda, scl_oe, sda_oe, scl_w, sda_w, stsp_irq;
    wire logic   tx_irq, rx_irq;
    logic [31:0] hrdata;
    int          n_start, n_stop, k0, k1;
    int          errors = 0;
    int          cmp_count = 0;
    int          cyc = 0;

    always #25 clk_sys = ~clk_sys;
    // The only slave's ready is the bus ready; lines are wired-AND.
    assign scl_w = ~(scl_oe | p_scl);
    assign sda_w = ~(sda_oe | p_sda);

    uime_engine u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hready), .hresp(), .scl_in(scl_w), .scl_out(),
        .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(), .sda_oe(sda_oe),
        .stsp_irq(stsp_irq), .tx_irq(tx_irq), .rx_irq(rx_irq),
        .dma1_req());
    uime_peer u_peer (.clk_sys(clk_sys), .scl(scl_w), .sda(sda_w),
        .scl_pull(p_scl), .sda_pull(p_sda), .n_start(n_start), .n_stop(n_stop));

    task automatic finish_test();
        $display("errors=%0d cmp_count=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test

    // Ceiling well above the few hundred cycles the sequence needs.
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            finish_test();
        end
    end

    task automatic check(input logic ok, input string s);
        cmp_count++;
        if (ok !== 1'b1) begin
            errors++;
            $display("[FAIL] %0t %s", $time, s);
        end
    endtask : check

    // One single transfer; address held until ready, then data phase.
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        @(posedge clk_sys);
        while (hready !== 1'b1) @(posedge clk_sys);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk_sys);
        while (hready !== 1'b1) @(posedge clk_sys);
        q = hrdata;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e, input string s);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check((q & m) === e, s);
    endtask : rd

    task automatic wait_stsp(input string s);
        int n;
        n = 0;
        while (stsp_irq !== 1'b1 && n < 300) begin
            @(posedge clk_sys);
            n++;
        end
        check(stsp_irq === 1'b1, s);
    endtask : wait_stsp

    // Main sequence: detection as a slave, then each condition as master.
    initial begin
        repeat (6) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        wr(ADDR_CTRL, 32'h100);
        wr(ADDR_BAUD, 32'h3);
        wr(ADDR_TXBUF, 32'hFF);
        wr(ADDR_CTRL, 32'h18A);
        check(sda_oe === 1'b0 && scl_oe === 1'b0, "idle lines driven");
        rd(ADDR_STATUS, 32'h3F, 32'h0, "status not clear");
        u_peer.gen_start();
        wait_stsp("start not flagged");
        rd(ADDR_STATUS, 32'h21, 32'h21, "start status wrong");
        wr(ADDR_STATUS, 32'h1);
        @(posedge clk_sys);
        check(stsp_irq === 1'b0, "request not cleared");
        u_peer.gen_stop();
        wait_stsp("stop not flagged");
        rd(ADDR_STATUS, 32'h21, 32'h1, "stop status wrong");
        wr(ADDR_STATUS, 32'h1F);
        wr(8'h1C, 32'hFFFFFFFF);
        rd(8'h1C, 32'hFFFFFFFF, 32'h0, "unmapped not zero");
        wr(ADDR_CTRL, 32'h10A);
        for (int i = 0; i < 3; i++) begin
            k0 = n_start;
            k1 = n_stop;
            wr(ADDR_MODE4, 32'h1 << i);
            repeat (80) @(posedge clk_sys);
            check(n_start == k0 && n_stop == k1, "made without select");
            check(tx_irq === (i > 0) && rx_irq === 1'b0,
                  "ninth clock source wrong");
            wr(ADDR_MODE4, (32'h1 << i) | 32'h8);
            wait_stsp("generation end not flagged");
            check(n_start - k0 == (i < 2) && n_stop - k1 == (i == 2),
                  "wrong condition on bus");
            rd(ADDR_MODE4, 32'h7, 32'h0, "request bit kept");
            rd(ADDR_STATUS, 32'h20, (i < 2) ? 32'h20 : 32'h0, "busy wrong");
            wr(ADDR_MODE4, 32'h0);
            wr(ADDR_STATUS, 32'h1F);
        end
        finish_test();
    end
endmodule : uime_engine_tb_top
`default_nettype wire
